/* pkg/pbs_defines.svh */
// Constants of the port-B bus sizer and byte swapper.
// Assumes inclusion by bare name from package and design files.
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

`define PBS_LONG_W 36
`define PBS_WORD_W 18
`define PBS_BYTE_W 9
`define PBS_SYNC_W 45
`define PBS_SWAP_NONE 2'h0
`define PBS_SWAP_BYTE 2'h1
`define PBS_SWAP_WORD 2'h2
`define PBS_SWAP_BOTH 2'h3
`define PBS_LAST_WORD 2'h1
`define PBS_LAST_BYTE 2'h3

`endif

/* pkg/pbs_pkg.sv */
// Types of the port-B bus sizer and byte swapper.
// Assumes pbs_defines.svh is on the include path.
`include "pbs_defines.svh"

package pbs_pkg;
  // Width modes, Gray coded; encoding is ours, decoded from the two width selects
  typedef enum logic [1:0] {
    PBS_SIZE_LONG = 2'h0,
    PBS_SIZE_WORD = 2'h1,
    PBS_SIZE_BYTE = 2'h3,
    PBS_SIZE_MAIL = 2'h2
  } pbs_size_t;
endpackage

/* design/pbs_swapper.sv */
// Byte reordering stage of the port-B datapath, purely combinational.
// Assumes the caller registers the result; both data directions use it.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_swapper
  import pbs_pkg::*;
(
  input wire logic [`PBS_LONG_W-1:0] data_in, // Long word before reordering
  input wire logic [1:0] swap_sel_in, // {reorder_select_lo, reorder_select_hi}
  output logic [`PBS_LONG_W-1:0] data_out // Reordered long word
);
  localparam int B = `PBS_BYTE_W;
  logic [B-1:0] b0, b1, b2, b3;

  assign b0 = data_in[B-1:0];
  assign b1 = data_in[2*B-1:B];
  assign b2 = data_in[3*B-1:2*B];
  assign b3 = data_in[4*B-1:3*B];

  // Whole 9-bit bytes move; bits inside each byte keep their order
  always_comb begin
    case (swap_sel_in)
      `PBS_SWAP_NONE: data_out = {b3, b2, b1, b0};
      `PBS_SWAP_BYTE: data_out = {b0, b1, b2, b3};
      `PBS_SWAP_WORD: data_out = {b1, b0, b3, b2};
      `PBS_SWAP_BOTH: data_out = {b2, b3, b0, b1};
      default: data_out = data_in;
    endcase
  end
endmodule

`default_nettype wire

/* design/pbs_port_b.sv */
// Port-B datapath stage of a clocked 36-bit FIFO: byte reordering and bus sizing.
// Assumes FIFO core, mailbox flags and parity live outside; the port-B clock
// and all port-B pins are foreign and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_port_b
  import pbs_pkg::*;
#(
  parameter int LONG_WIDTH = `PBS_LONG_W
) (
  input wire logic clock_in, // System clock, 100 MHz
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic port_b_clock_in, // Port-B clock pin, sampled
  input wire logic port_b_chip_select_n_in, // Port-B select, active low
  input wire logic port_b_enable_in, // Port-B transfer enable, active high
  input wire logic port_b_write_select_in, // High: write into device, low: read
  input wire logic endian_order_select_n_in, // Low big-endian, high little-endian
  input wire logic width_select_lo_in, // Lower width select
  input wire logic width_select_hi_in, // Upper width select
  input wire logic reorder_select_lo_in, // Lower swap select
  input wire logic reorder_select_hi_in, // Upper swap select
  input wire logic [`PBS_LONG_W-1:0] port_b_lines_in, // Port-B lines, pin level
  output logic [`PBS_LONG_W-1:0] port_b_lines_out, // Port-B lines, driven value
  output logic port_b_lines_oe_out, // High while the device drives the lines
  input wire logic [`PBS_LONG_W-1:0] fifo_rd_data_in, // Head word of the FIFO
  input wire logic fifo_rd_valid_in, // FIFO holds a word
  output logic fifo_rd_pop_out, // One-cycle pulse: head word consumed
  output logic [`PBS_LONG_W-1:0] fifo_wr_data_out, // Assembled long word
  output logic fifo_wr_push_out, // One-cycle pulse: store fifo_wr_data_out
  input wire logic [`PBS_LONG_W-1:0] outbound_mailbox_in, // Outbound mailbox contents
  output logic [`PBS_LONG_W-1:0] inbound_mailbox_out, // Inbound mailbox register
  output logic inbound_mailbox_write_out // One-cycle pulse: inbound mailbox loaded
);
  localparam int B = `PBS_BYTE_W;
  localparam int W = `PBS_WORD_W;
  localparam int L = `PBS_LONG_W;

  // Elaboration-time refusal: the lane slicing is fixed to four 9-bit bytes
  if (LONG_WIDTH != `PBS_LONG_W) begin : g_width_check
    $error("pbs_port_b serves only a 36-bit long word");
  end

  // Two-flop synchroniser; stage one is read by stage two only
  logic [`PBS_SYNC_W-1:0] sync1_q, sync2_q, pins;
  logic clk_prev_q;
  // Idle levels: link clock high and deselected, so a pin high at release makes no edge
  localparam logic [`PBS_SYNC_W-1:0] SYNC_IDLE = {2'b11, {(`PBS_SYNC_W-2){1'b0}}};
  assign pins = {port_b_clock_in, port_b_chip_select_n_in, port_b_enable_in,
                 port_b_write_select_in, endian_order_select_n_in, width_select_lo_in,
                 width_select_hi_in, reorder_select_lo_in, reorder_select_hi_in,
                 port_b_lines_in[L-1:1], port_b_lines_in[0]};

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
      clk_prev_q <= 1'b1;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[`PBS_SYNC_W-1];
    end
  end

  logic b_clk_s, cs_n_s, en_s, wr_s, le_s, wlo_s, whi_s, slo_s, shi_s;
  logic [L-1:0] lines_s;
  assign {b_clk_s, cs_n_s, en_s, wr_s, le_s, wlo_s, whi_s, slo_s, shi_s, lines_s} = sync2_q;

  // One transfer per rising port-B clock edge while selected and enabled
  logic xfer;
  assign xfer = b_clk_s & ~clk_prev_q & ~cs_n_s & en_s;

  pbs_size_t live_mode;
  always_comb begin
    case ({whi_s, wlo_s})
      2'b00: live_mode = PBS_SIZE_LONG;
      2'b10: live_mode = PBS_SIZE_WORD;
      2'b01: live_mode = PBS_SIZE_BYTE;
      2'b11: live_mode = PBS_SIZE_MAIL;
      default: live_mode = PBS_SIZE_LONG;
    endcase
  end

  // Configuration of the long word in progress
  logic [1:0] phase_q;
  pbs_size_t cfg_mode_q;
  logic cfg_le_q;
  logic [1:0] cfg_swap_q;
  pbs_size_t mode;
  logic le;
  logic [1:0] swap;
  logic first;
  assign first = (phase_q == 2'h0);
  assign mode = first ? live_mode : cfg_mode_q;
  assign le = first ? le_s : cfg_le_q;
  assign swap = first ? {slo_s, shi_s} : cfg_swap_q;

  logic [1:0] last;
  assign last = (mode == PBS_SIZE_BYTE) ? `PBS_LAST_BYTE : `PBS_LAST_WORD;
  logic narrow;
  assign narrow = (mode == PBS_SIZE_WORD) || (mode == PBS_SIZE_BYTE);
  // Element of the long word carried by this transfer
  logic [1:0] elem;
  assign elem = le ? phase_q : 2'(last - phase_q);

  // Read path: swap first, then size
  logic [L-1:0] rd_swapped, hold_q, rd_word;
  pbs_swapper u_rd_swap (
    .data_in(fifo_rd_data_in),
    .swap_sel_in(swap),
    .data_out(rd_swapped)
  );
  assign rd_word = first ? rd_swapped : hold_q;

  logic [W-1:0] rd_elem;
  always_comb begin
    if (mode == PBS_SIZE_BYTE) begin
      rd_elem = {{(W-B){1'b0}}, rd_word[elem*B +: B]};
    end else begin
      rd_elem = rd_word[elem[0]*W +: W];
    end
  end

  logic rd_go;
  assign rd_go = xfer & ~wr_s & (fifo_rd_valid_in | ~first);

  // Write path: size first, then swap
  logic [L-1:0] asm_q, wr_asm, wr_swapped;
  always_comb begin
    wr_asm = asm_q;
    case (mode)
      PBS_SIZE_BYTE: wr_asm[elem*B +: B] = le ? lines_s[B-1:0] : lines_s[L-1:L-B];
      PBS_SIZE_WORD: wr_asm[elem[0]*W +: W] = le ? lines_s[W-1:0] : lines_s[L-1:W];
      default: wr_asm = lines_s;
    endcase
  end
  pbs_swapper u_wr_swap (
    .data_in(wr_asm),
    .swap_sel_in(swap),
    .data_out(wr_swapped)
  );

  logic advance;
  assign advance = narrow & ((xfer & wr_s) | rd_go);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      phase_q <= 2'h0;
      cfg_mode_q <= PBS_SIZE_LONG;
      cfg_le_q <= 1'b0;
      cfg_swap_q <= `PBS_SWAP_NONE;
    end else if (advance) begin
      phase_q <= (phase_q == last) ? 2'h0 : 2'(phase_q + 2'h1);
      if (first) begin
        cfg_mode_q <= live_mode;
        cfg_le_q <= le_s;
        cfg_swap_q <= {slo_s, shi_s};
      end
    end
  end

  // Read lanes; lanes not in use keep their last value
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      port_b_lines_out <= '0;
      hold_q <= '0;
      fifo_rd_pop_out <= 1'b0;
    end else begin
      fifo_rd_pop_out <= 1'b0;
      if (xfer & ~wr_s) begin
        case (mode)
          PBS_SIZE_MAIL: port_b_lines_out <= outbound_mailbox_in;
          PBS_SIZE_LONG: begin
            if (fifo_rd_valid_in) begin
              port_b_lines_out <= rd_swapped;
              fifo_rd_pop_out <= 1'b1;
            end
          end
          default: begin
            if (rd_go) begin
              if (first) begin
                hold_q <= rd_swapped;
                fifo_rd_pop_out <= 1'b1;
              end
              if (mode == PBS_SIZE_BYTE && le) begin
                port_b_lines_out[B-1:0] <= rd_elem[B-1:0];
              end else if (mode == PBS_SIZE_BYTE) begin
                port_b_lines_out[L-1:L-B] <= rd_elem[B-1:0];
              end else if (le) begin
                port_b_lines_out[W-1:0] <= rd_elem;
              end else begin
                port_b_lines_out[L-1:W] <= rd_elem;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      port_b_lines_oe_out <= 1'b0;
    end else begin
      port_b_lines_oe_out <= ~cs_n_s & ~wr_s;
    end
  end

  // Write side: assembly, FIFO push and inbound mailbox
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      asm_q <= '0;
      fifo_wr_data_out <= '0;
      fifo_wr_push_out <= 1'b0;
      inbound_mailbox_out <= '0;
      inbound_mailbox_write_out <= 1'b0;
    end else begin
      fifo_wr_push_out <= 1'b0;
      inbound_mailbox_write_out <= 1'b0;
      if (xfer & wr_s) begin
        if (mode == PBS_SIZE_MAIL) begin
          inbound_mailbox_out <= lines_s;
          inbound_mailbox_write_out <= 1'b1;
        end else if (!narrow || phase_q == last) begin
          fifo_wr_data_out <= wr_swapped;
          fifo_wr_push_out <= 1'b1;
        end else begin
          asm_q <= wr_asm;
        end
      end
    end
  end

  // Checks
  AST_WORD_BE: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && mode == PBS_SIZE_WORD && !le |=> port_b_lines_out[L-1:W] == $past(rd_elem))
    else $error("big-endian word not on upper half");
  AST_WORD_LE: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && mode == PBS_SIZE_WORD && le |=> port_b_lines_out[W-1:0] == $past(rd_elem))
    else $error("little-endian word not on lower half");
  AST_BYTE_BE: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && mode == PBS_SIZE_BYTE && !le
    |=> port_b_lines_out[L-1:L-B] == $past(rd_elem[B-1:0]))
    else $error("big-endian byte not on top lanes");
  AST_BYTE_LE_HOLD: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && mode == PBS_SIZE_BYTE && le
    |=> port_b_lines_out[L-1:B] == $past(port_b_lines_out[L-1:B]))
    else $error("unused lanes changed");
  AST_BYTE_FOUR: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && mode == PBS_SIZE_BYTE && phase_q == 2'h3 |=> phase_q == 2'h0)
    else $error("byte read did not end after four transfers");
  AST_POP_FIRST: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && narrow && !first |=> !fifo_rd_pop_out)
    else $error("FIFO popped mid long word");
  AST_CFG_HELD: assert property (@(posedge clock_in) disable iff (reset_in)
    !first && !$past(first) |-> $stable(cfg_mode_q) && $stable(cfg_le_q))
    else $error("configuration changed mid long word");
  AST_MAIL_RD: assert property (@(posedge clock_in) disable iff (reset_in)
    xfer && !wr_s && mode == PBS_SIZE_MAIL |=> port_b_lines_out == $past(outbound_mailbox_in))
    else $error("outbound mailbox not driven");
  AST_MAIL_WR: assert property (@(posedge clock_in) disable iff (reset_in)
    xfer && wr_s && mode == PBS_SIZE_MAIL
    |=> inbound_mailbox_write_out && !fifo_wr_push_out && inbound_mailbox_out == $past(lines_s))
    else $error("inbound mailbox not loaded");
  AST_LONG_RD: assert property (@(posedge clock_in) disable iff (reset_in)
    xfer && !wr_s && mode == PBS_SIZE_LONG && fifo_rd_valid_in
    |=> fifo_rd_pop_out && port_b_lines_out == $past(rd_swapped))
    else $error("long word read wrong");
  AST_BYTE_LE: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_go && mode == PBS_SIZE_BYTE && le
    |=> port_b_lines_out[B-1:0] == $past(rd_elem[B-1:0]))
    else $error("little-endian byte not on low lanes");
  AST_PUSH_LAST: assert property (@(posedge clock_in) disable iff (reset_in)
    xfer && wr_s && narrow && phase_q != last |=> !fifo_wr_push_out)
    else $error("FIFO written before the long word was complete");
  AST_WORD_TWO: assert property (@(posedge clock_in) disable iff (reset_in)
    advance && mode == PBS_SIZE_WORD && phase_q == 2'h1 |=> phase_q == 2'h0)
    else $error("word transfer did not end after two halves");
endmodule

`default_nettype wire

/* verif/pbs_bus_master.sv */
// Narrow port-B bus master: makes the link clock and drives one transfer at a time.
// Assumes clock_in is the 100 MHz system clock; the link period is 80 ns.
`timescale 1ns/100ps
`default_nettype none

module pbs_bus_master (
  input wire logic clock_in, // System clock, paces the link
  output logic port_b_clock_out, // Link clock, still between transfers
  output logic chip_select_n_out, // Active-low select
  output logic enable_out, // Transfer enable
  output logic write_out, // High: write into device
  output logic endian_n_out, // High: little-endian
  output logic width_lo_out, // Lower width select
  output logic width_hi_out, // Upper width select
  output logic reorder_lo_out, // Lower swap select
  output logic reorder_hi_out, // Upper swap select
  output logic [35:0] lines_out // Lines driven toward the device
);
  initial begin
    {port_b_clock_out, chip_select_n_out, enable_out, write_out, endian_n_out} = 5'h08;
    {width_lo_out, width_hi_out, reorder_lo_out, reorder_hi_out} = 4'h0;
    lines_out = 36'h0;
  end

  task automatic xfer(input logic wr, input logic [1:0] size, input logic end_n,
                      input logic [1:0] sel, input logic [35:0] d);
    @(posedge clock_in);
    {chip_select_n_out, enable_out, write_out} <= {1'h0, 1'h1, wr};
    {width_hi_out, width_lo_out, endian_n_out} <= {size, end_n};
    {reorder_lo_out, reorder_hi_out} <= sel;
    lines_out <= wr ? d : ~lines_out;
    // Low 40 ns, high 40 ns: back-to-back calls give an 80 ns link clock
    repeat (3) @(posedge clock_in);
    port_b_clock_out <= 1'h1;
    repeat (4) @(posedge clock_in);
    // Released lines show the inverse so a stale value never matches by luck
    {port_b_clock_out, chip_select_n_out, enable_out} <= {1'h0, 1'h1, 1'h0};
    lines_out <= ~lines_out;
  endtask
endmodule

`default_nettype wire

/* verif/tb_pbs_port_b.sv */
// Self-checking bench of the port-B sizer and swapper.
// Assumes pbs_bus_master plays the narrow bus; the FIFO and mailbox are plain registers here.
`timescale 1ns/100ps
`default_nettype none

module tb_pbs_port_b;
  import pbs_pkg::*;
  typedef struct packed {
    logic we;
    logic [1:0] size;
    logic e;
    logic [1:0] sel;
    logic [35:0] w;
  } pbs_row_t;
  logic clock_in = 1'h0;
  logic reset_in = 1'h1;
  logic pbc, csn, en, we, endn, wlo, whi, slo, shi, oe, pop, push, inbox_wr;
  logic [35:0] lines_b, lines_out, wr_data, inbox, exp_q;
  logic [35:0] fifo_q = 36'h0;
  logic [35:0] mbox_q = 36'hF0E1D2C3B;
  logic valid_q = 1'h1;
  int n_errors = 0;
  int checks = 0;
  int n_pop = 0;
  int n_push = 0;
  int n_mail = 0;
  pbs_row_t rows [12] = '{
    '{1'h0, 2'h0, 1'h1, 2'h0, 36'h123456789}, '{1'h0, 2'h2, 1'h0, 2'h1, 36'h13579BDF0},
    '{1'h0, 2'h2, 1'h1, 2'h2, 36'h2468ACE13}, '{1'h0, 2'h1, 1'h1, 2'h1, 36'h0FEDCBA98},
    '{1'h0, 2'h1, 1'h0, 2'h3, 36'h8A1B2C3D4}, '{1'h0, 2'h3, 1'h0, 2'h0, 36'h000000000},
    '{1'h1, 2'h1, 1'h1, 2'h1, 36'h9C8B7A695}, '{1'h1, 2'h1, 1'h0, 2'h2, 36'h1F2E3D4C5},
    '{1'h1, 2'h2, 1'h0, 2'h3, 36'h6B5A49382}, '{1'h1, 2'h2, 1'h1, 2'h0, 36'h7C6D5E4F3},
    '{1'h1, 2'h0, 1'h0, 2'h3, 36'hE0D1C2B3A}, '{1'h1, 2'h3, 1'h1, 2'h2, 36'h3A4B5C6D7}};

  always #5 clock_in = ~clock_in;

  // Pulses are counted mid-cycle, clear of the edge that launches them
  always @(negedge clock_in) begin
    if (pop === 1'h1) n_pop++;
    if (push === 1'h1) n_push++;
    if (inbox_wr === 1'h1) n_mail++;
  end

  pbs_bus_master mst (.clock_in(clock_in), .port_b_clock_out(pbc), .chip_select_n_out(csn),
    .enable_out(en), .write_out(we), .endian_n_out(endn), .width_lo_out(wlo),
    .width_hi_out(whi), .reorder_lo_out(slo), .reorder_hi_out(shi), .lines_out(lines_b));

  pbs_port_b uut (.clock_in(clock_in), .reset_in(reset_in), .port_b_clock_in(pbc),
    .port_b_chip_select_n_in(csn), .port_b_enable_in(en), .port_b_write_select_in(we),
    .endian_order_select_n_in(endn), .width_select_lo_in(wlo), .width_select_hi_in(whi),
    .reorder_select_lo_in(slo), .reorder_select_hi_in(shi), .port_b_lines_in(lines_b),
    .port_b_lines_out(lines_out), .port_b_lines_oe_out(oe), .fifo_rd_data_in(fifo_q),
    .fifo_rd_valid_in(valid_q), .fifo_rd_pop_out(pop), .fifo_wr_data_out(wr_data),
    .fifo_wr_push_out(push), .outbound_mailbox_in(mbox_q), .inbound_mailbox_out(inbox),
    .inbound_mailbox_write_out(inbox_wr));

  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] sel);
    case (sel)
      2'h1: swp = {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: swp = {w[17:9], w[8:0], w[35:27], w[26:18]};
      2'h3: swp = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: swp = w;
    endcase
  endfunction

  // One long word; with bad set, later transfers carry a different width and order
  task automatic do_row(input pbs_row_t r, input logic bad);
    int n, wdt, off, idx, p0, p1, p2;
    logic [35:0] s, m, c, d;
    @(posedge clock_in);
    fifo_q <= r.w;
    n = (r.size == 2'h1) ? 4 : (r.size == 2'h2) ? 2 : 1;
    wdt = 36 / n;
    m = (36'h1 << wdt) - 36'h1;
    off = (r.e || n == 1) ? 0 : 36 - wdt;
    s = swp(r.w, r.sel);
    p0 = n_pop;
    p1 = n_push;
    p2 = n_mail;
    for (int k = 0; k < n; k++) begin
      idx = r.e ? k : n - 1 - k;
      c = (s >> (idx * wdt)) & m;
      if (r.size == 2'h3) c = r.we ? r.w : mbox_q;
      d = (c << off) | (~(m << off) & 36'h5A5A5A5A5);
      // Swap selects stand for the first transfer only; later ones drop them
      mst.xfer(r.we, (bad && k > 0) ? 2'h2 : r.size, r.e ^ (bad && k > 0),
               (k == 0) ? r.sel : 2'h0, d);
      chk(36'(oe), 36'(!r.we));
      if (!r.we) begin
        exp_q = (exp_q & ~(m << off)) | (c << off);
        chk(lines_out, exp_q);
      end
    end
    if (r.we && r.size == 2'h3) begin
      chk(inbox, r.w);
      chk(36'(n_mail - p2), 36'h1);
    end else if (r.we) begin
      chk(wr_data, r.w);
      chk(36'(n_push - p1), 36'h1);
    end else begin
      chk(36'(n_pop - p0), (r.size == 2'h3) ? 36'h0 : 36'h1);
    end
  endtask

  initial begin
    int p;
    exp_q = 36'h0;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    chk(lines_out, 36'h0);
    chk(36'(oe), 36'h0);
    for (int i = 0; i < 12; i++) begin
      do_row(rows[i], 1'h0);
    end
    do_row(rows[3], 1'h1);
    // Empty FIFO: first narrow read is ignored and the phase stays put
    valid_q <= 1'h0;
    p = n_pop;
    mst.xfer(1'h0, 2'h1, 1'h1, 2'h0, 36'h0);
    chk(lines_out, exp_q);
    chk(36'(n_pop - p), 36'h0);
    valid_q <= 1'h1;
    do_row(rows[4], 1'h0);
    // Reset in mid-word clears the lanes and restarts the phase
    mst.xfer(1'h0, 2'h1, 1'h0, 2'h0, 36'h0);
    reset_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    chk(lines_out, 36'h0);
    chk(36'(oe), 36'h0);
    exp_q = 36'h0;
    do_row(rows[4], 1'h0);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clock_in);
    n_errors++;
    summarize();
  end
endmodule

`default_nettype wire
